// ===== verilog/flash_cfg_defines.svh
// Command codes, field positions, reset values and timing counts of the
// enhanced volatile configuration block.
// Assumes nothing; included by bare name from the package, the configuration block and its bench.
`ifndef FLASH_CFG_DEFINES_SVH
`define FLASH_CFG_DEFINES_SVH

// ==================================================================
// Register layout
`define CFG_QUAD_BIT 7
`define CFG_DUAL_BIT 6
`define CFG_RSVD_BIT 5
`define CFG_HOLD_BIT 4
`define CFG_ACCEL_BIT 3
`define CFG_DRIVE_MSB 2
`define CFG_DRIVE_LSB 0
`define CFG_RESET_VAL 8'hDF
`define CFG_WRITE_MASK 8'hDF

// ==================================================================
// Command codes, plain defaults for the module parameters
`define OP_WRITE_CFG 8'hA1
`define OP_QUAD_PAGE_PROG 8'hA2
`define OP_QUAD_FAST_PROG 8'hA3
`define OP_QUAD_EXT_FAST_PROG 8'hA4
`define OP_SECTOR_ERASE 8'hA5
`define OP_SUBSECTOR_ERASE 8'hA6
`define OP_BULK_ERASE 8'hA7

// Opcode, three address bytes and at least one data byte.
`define PROG_MIN_BYTES 3'd5

// ==================================================================
// Timing
`define CLK_HZ 50000000
`define VPP_TIMEOUT_MS 200
`define VPP_TIMEOUT_CYC ((`CLK_HZ / 1000) * `VPP_TIMEOUT_MS)

`endif

// ===== verilog/flash_cfg_pkg.sv
// Types shared by the configuration block and its lane shifter.
// Assumes the defines header sits in the include path.
`include "flash_cfg_defines.svh"

package flash_cfg_pkg;

    // Command protocol on the serial lines.
    typedef enum logic [1:0] {
        PROTO_EXT,
        PROTO_DUAL,
        PROTO_QUAD
    } proto_e;

    // Enhanced volatile configuration byte, bit 7 first.
    typedef struct packed {
        logic quad_off;
        logic dual_off;
        logic rsvd;
        logic hold_en;
        logic accel_off;
        logic [2:0] drive;
    } cfg_s;

    // Synchronised serial pins.
    typedef struct packed {
        logic cs_n;
        logic sck;
        logic vpp_high;
        logic [3:0] dq;
    } pins_s;

endpackage : flash_cfg_pkg

// ===== verilog/spi_lane_shifter.sv
// Serial-to-parallel shifter taking one, two or four bits per clock edge.
// Assumes shift is a one-cycle strobe on the system clock and din is
// already synchronised.
`timescale 1ns/100ps
`default_nettype none

module spi_lane_shifter
    import flash_cfg_pkg::*;
#(
    parameter int W = 8
) (
    input wire logic clk,
    input wire logic resetn,
    input wire logic ce,
    input wire logic clear,
    input wire logic shift,
    input wire proto_e mode,
    input wire logic [3:0] din,
    output logic [W-1:0] word_r,
    output logic done_r
);

    localparam int CW = $clog2(W) + 2;

    logic [CW-1:0] cnt_r;
    logic [CW-1:0] step;
    logic [CW-1:0] cnt_nxt;
    logic [W-1:0] shifted;
    logic full;

    // ==============================================================
    // Lane selection: most significant lane arrives first.
    assign step = (mode == PROTO_QUAD) ? CW'(4) :
                  (mode == PROTO_DUAL) ? CW'(2) : CW'(1);
    assign shifted = (mode == PROTO_QUAD) ? {word_r[W-5:0], din} :
                     (mode == PROTO_DUAL) ? {word_r[W-3:0], din[1:0]} :
                     {word_r[W-2:0], din[0]};
    assign cnt_nxt = cnt_r + step;
    assign full = (cnt_nxt >= CW'(W));

    // ==============================================================
    // Shift and count; done pulses with the completed word.
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            cnt_r <= '0;
            word_r <= '0;
            done_r <= 1'b0;
        end else if (ce) begin
            done_r <= shift & full & ~clear;
            if (clear) begin
                cnt_r <= '0;
            end else if (shift) begin
                word_r <= shifted;
                cnt_r <= full ? '0 : cnt_nxt;
            end
        end
    end

endmodule : spi_lane_shifter

`default_nettype wire

// ===== verilog/enhanced_volatile_config.sv
// Enhanced volatile configuration register of a serial flash, with
// protocol selection, hold/reset enable, accelerating-voltage control and
// the accelerating-voltage timeout.
// Assumes serial pins and the high-voltage comparator are asynchronous to
// clk; non-volatile defaults and the error clear come from clk logic.
`timescale 1ns/100ps
`default_nettype none

`include "flash_cfg_defines.svh"

module enhanced_volatile_config
    import flash_cfg_pkg::*;
#(
    parameter int TIMEOUT_CYCLES = `VPP_TIMEOUT_CYC,
    parameter int TIMER_W = 24,
    parameter logic [7:0] OP_WRITE = `OP_WRITE_CFG,
    parameter logic [7:0] OP_QPP = `OP_QUAD_PAGE_PROG,
    parameter logic [7:0] OP_QFP = `OP_QUAD_FAST_PROG,
    parameter logic [7:0] OP_QEFP = `OP_QUAD_EXT_FAST_PROG,
    parameter logic [7:0] OP_SE = `OP_SECTOR_ERASE,
    parameter logic [7:0] OP_SSE = `OP_SUBSECTOR_ERASE,
    parameter logic [7:0] OP_BE = `OP_BULK_ERASE
) (
    input wire logic clk,
    input wire logic resetn,
    input wire logic ce,
    input wire logic cs_n_pin,
    input wire logic sck_pin,
    input wire logic [3:0] dq_pin,
    input wire logic vpp_high_pin,
    input wire logic nonvolatile_config_reg_hold_en,
    input wire logic [2:0] nonvolatile_config_reg_drive,
    input wire logic vpp_error_clear,
    output cfg_s cfg_r,
    output proto_e active_proto_r,
    output logic hold_reset_en_r,
    output logic [2:0] drive_code_r,
    output logic io2_accel_pin_en_r,
    output logic temp_ext_r,
    output logic accel_active_r,
    output logic vpp_error_r
);

    // ==============================================================
    // Pin synchronisers
    pins_s sync1_r;
    pins_s sync2_r;
    logic sck_d_r;
    logic cs_d_r;
    logic vpp_d_r;

    // Stage one feeds stage two only; edges are taken from stage two.
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            sync1_r <= '{cs_n: 1'b1, sck: 1'b0, vpp_high: 1'b0, dq: 4'h0};
            sync2_r <= '{cs_n: 1'b1, sck: 1'b0, vpp_high: 1'b0, dq: 4'h0};
            sck_d_r <= 1'b0;
            cs_d_r <= 1'b1;
            vpp_d_r <= 1'b0;
        end else if (ce) begin
            sync1_r <= '{cs_n: cs_n_pin, sck: sck_pin,
                         vpp_high: vpp_high_pin, dq: dq_pin};
            sync2_r <= sync1_r;
            sck_d_r <= sync2_r.sck;
            cs_d_r <= sync2_r.cs_n;
            vpp_d_r <= sync2_r.vpp_high;
        end
    end

    logic selected;
    logic sck_rise;
    logic cs_rise;
    logic vpp_hi;
    logic vpp_fall;

    // Edge detection on the synchronised copies.
    assign selected = ~sync2_r.cs_n;
    assign sck_rise = sync2_r.sck & ~sck_d_r & selected;
    assign cs_rise = sync2_r.cs_n & ~cs_d_r;
    assign vpp_hi = sync2_r.vpp_high;
    assign vpp_fall = ~sync2_r.vpp_high & vpp_d_r;

    // ==============================================================
    // Byte assembly in the active protocol
    logic [7:0] rx_byte;
    logic rx_done;

    // Temporary extended mode is part of active_proto_r, so polling and
    // suspend commands are shifted in on one lane while io2 holds Vpp.
    spi_lane_shifter #(
        .W(8)
    ) u_shifter (
        .clk(clk),
        .resetn(resetn),
        .ce(ce),
        .clear(~selected),
        .shift(sck_rise),
        .mode(active_proto_r),
        .din(sync2_r.dq),
        .word_r(rx_byte),
        .done_r(rx_done)
    );

    logic [2:0] byte_cnt_r;
    logic [7:0] opcode_r;
    logic [7:0] wr_data_r;
    logic wr_have_r;

    // Frame bookkeeping; the count saturates, larger frames need no more.
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            byte_cnt_r <= 3'd0;
            opcode_r <= 8'h00;
            wr_data_r <= 8'h00;
            wr_have_r <= 1'b0;
        end else if (ce) begin
            if (!selected) begin
                byte_cnt_r <= 3'd0;
                wr_have_r <= 1'b0;
            end else if (rx_done) begin
                if (byte_cnt_r != 3'd7) begin
                    byte_cnt_r <= byte_cnt_r + 3'd1;
                end
                if (byte_cnt_r == 3'd0) begin
                    opcode_r <= rx_byte;
                end
                if (byte_cnt_r == 3'd1 && opcode_r == OP_WRITE) begin
                    wr_data_r <= rx_byte;
                    wr_have_r <= 1'b1;
                end
            end
        end
    end

    // ==============================================================
    // Command classification at deselect
    logic commit;
    logic is_qpp;
    logic is_qfp;
    logic is_erase;
    logic prog_full;
    logic in_quad;
    logic accel_en;
    logic quad_modify;
    logic temp_start;

    // Only a completed data byte commits; a frame cut short is dropped.
    assign commit = cs_rise & wr_have_r & (opcode_r == OP_WRITE);
    assign is_qpp = (opcode_r == OP_QPP);
    assign is_qfp = (opcode_r == OP_QFP) | (opcode_r == OP_QEFP);
    // An empty frame must not replay the opcode left by the last one.
    assign is_erase = ((opcode_r == OP_SE) | (opcode_r == OP_SSE) |
                       (opcode_r == OP_BE)) & (byte_cnt_r != 3'd0);
    assign prog_full = (byte_cnt_r >= `PROG_MIN_BYTES);
    assign in_quad = (active_proto_r == PROTO_QUAD);
    assign accel_en = ~cfg_r.accel_off;
    // Outside quad protocol the enable bit matters for quad fast
    // programs alone; every other command ignores it.
    assign quad_modify = cs_rise & accel_en &
        ((in_quad & (((is_qpp | is_qfp) & prog_full) | is_erase)) |
         (~in_quad & is_qfp & prog_full));
    assign temp_start = cs_rise & accel_en & in_quad &
                        ((is_qpp & prog_full) | is_erase);

    // ==============================================================
    // Configuration register
    cfg_s cfg_wr;
    cfg_s cfg_nxt;
    logic load_pend_r;

    assign cfg_wr = cfg_s'(wr_data_r & `CFG_WRITE_MASK);
    // The non-volatile defaults are caught on the first enabled cycle
    // after reset release, never through the asynchronous reset.
    assign cfg_nxt = load_pend_r ?
        '{quad_off: cfg_r.quad_off, dual_off: cfg_r.dual_off,
          rsvd: 1'b0, hold_en: nonvolatile_config_reg_hold_en,
          accel_off: cfg_r.accel_off, drive: nonvolatile_config_reg_drive} :
        commit ? cfg_wr : cfg_r;

    // Both protocol bits come out of reset at one.
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            cfg_r <= cfg_s'(`CFG_RESET_VAL);
            load_pend_r <= 1'b1;
        end else if (ce) begin
            cfg_r <= cfg_nxt;
            load_pend_r <= 1'b0;
        end
    end

    // ==============================================================
    // Protocol arbitration
    proto_e proto_nxt;

    assign proto_nxt = temp_ext_r ? PROTO_EXT :
                       ~cfg_r.quad_off ? PROTO_QUAD :
                       ~cfg_r.dual_off ? PROTO_DUAL :
                       PROTO_EXT;

    // Output drivers, hold enable and drive code follow the register.
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            active_proto_r <= PROTO_EXT;
            hold_reset_en_r <= 1'b1;
            drive_code_r <= 3'h7;
        end else if (ce) begin
            active_proto_r <= proto_nxt;
            hold_reset_en_r <= cfg_r.hold_en;
            drive_code_r <= cfg_r.drive;
        end
    end

    // ==============================================================
    // Accelerating-voltage window and timeout
    logic timing_r;
    logic [TIMER_W-1:0] timer_r;
    logic expire;
    logic got_vpp;

    assign got_vpp = timing_r & vpp_hi;
    assign expire = timing_r & ~vpp_hi & (timer_r == TIMER_W'(1));

    // A new quad modify restarts the window; voltage arriving in time
    // ends it with acceleration, expiry ends it at normal speed.
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            timing_r <= 1'b0;
            timer_r <= '0;
            accel_active_r <= 1'b0;
            io2_accel_pin_en_r <= 1'b0;
        end else if (ce) begin
            io2_accel_pin_en_r <= timing_r | accel_active_r;
            if (quad_modify) begin
                timing_r <= 1'b1;
                timer_r <= TIMER_W'(TIMEOUT_CYCLES);
            end else if (got_vpp | expire) begin
                timing_r <= 1'b0;
            end else if (timing_r) begin
                timer_r <= timer_r - TIMER_W'(1);
            end
            if (got_vpp) begin
                accel_active_r <= 1'b1;
            end else if (vpp_fall) begin
                accel_active_r <= 1'b0;
            end
        end
    end

    // Temporary extended protocol; an expired window also ends it, since
    // the voltage then never rises and could not fall back.
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            temp_ext_r <= 1'b0;
        end else if (ce) begin
            if (temp_start) begin
                temp_ext_r <= 1'b1;
            end else if ((accel_active_r & vpp_fall) | expire) begin
                temp_ext_r <= 1'b0;
            end
        end
    end

    // Sticky error; a new expiry beats a clear in the same cycle.
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            vpp_error_r <= 1'b0;
        end else if (ce) begin
            if (expire) begin
                vpp_error_r <= 1'b1;
            end else if (vpp_error_clear) begin
                vpp_error_r <= 1'b0;
            end
        end
    end

    // ==============================================================
    // Checks
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!resetn);

    chk_quad_priority: assert property (
        (ce && !cfg_r.quad_off && !temp_ext_r) |=>
            active_proto_r == PROTO_QUAD)
        else $error("quad not selected while quad bit clear");

    chk_dual_select: assert property (
        (ce && cfg_r.quad_off && !cfg_r.dual_off && !temp_ext_r) |=>
            active_proto_r == PROTO_DUAL)
        else $error("dual not selected");

    chk_ext_return: assert property (
        (ce && cfg_r.quad_off && cfg_r.dual_off) |=>
            active_proto_r == PROTO_EXT)
        else $error("extended not selected with both bits set");

    chk_temp_forces_ext: assert property (
        (ce && temp_ext_r) |=> active_proto_r == PROTO_EXT)
        else $error("temporary extended not honoured");

    chk_reserved_zero: assert property (
        cfg_r.rsvd == 1'b0)
        else $error("reserved bit not zero");

    chk_write_commit: assert property (
        (ce && commit && !load_pend_r) |=> cfg_r == $past(cfg_wr)
            ##1 ((!$past(ce)) || hold_reset_en_r == cfg_r.hold_en
                 || $past(commit)))
        else $error("write did not update configuration");

    chk_timeout_flag: assert property (
        (ce && timing_r && !vpp_hi && timer_r == TIMER_W'(1)) |=>
            vpp_error_r && (!timing_r || $past(quad_modify)))
        else $error("timeout did not raise error");

    chk_error_sticky: assert property (
        (vpp_error_r && !(ce && vpp_error_clear)) |=> vpp_error_r)
        else $error("voltage error lost without clear");

    chk_accel_ignored: assert property (
        (cs_rise && cfg_r.accel_off) |=> !timing_r || $past(timing_r))
        else $error("window opened with accelerator disabled");

    chk_temp_start: assert property (
        (ce && temp_start) |=> temp_ext_r ##1
            (!$past(ce) || active_proto_r == PROTO_EXT))
        else $error("temporary extended not entered");

endmodule : enhanced_volatile_config

`default_nettype wire

// ===== bench/spi_host_model.sv
// Behavioural host controller driving the serial pins of the config block.
// Assumes clk is the 50 MHz device clock; serial clock period is 160 ns.
`timescale 1ns/100ps
`default_nettype none

module spi_host_model
    import flash_cfg_pkg::*;
(
    input wire logic clk,
    output logic cs_n,
    output logic sck,
    output logic [3:0] dq,
    output logic vpp_high
);
    // ==================================================================
    // Idle levels: deselected, serial clock parked low.
    initial begin
        cs_n = 1'b1;
        sck = 1'b0;
        dq = 4'hA;
        vpp_high = 1'b0;
    end

    // ==================================================================
    // Frame driver, MSB first, lanes chosen by the protocol in force.
    // Unused lanes carry the inverse of their last value, never a
    // friendly constant, so a lane mix-up shows as corrupt data.
    task automatic send(input logic [39:0] data, input int n,
                        input proto_e p);
        int w;
        logic [7:0] b;
        logic [3:0] m;
        w = (p == PROTO_QUAD) ? 4 : (p == PROTO_DUAL) ? 2 : 1;
        m = 4'((1 << w) - 1);
        @(posedge clk) #1 cs_n = 1'b0;
        for (int k = 0; k < n; k++) begin
            b = data[39 - 8 * k -: 8];
            for (int s = 0; s < 8 / w; s++) begin
                #1 dq = (~dq & ~m) | (4'(b >> (8 - w * (s + 1))) & m);
                repeat (4) @(posedge clk);
                #1 sck = 1'b1;
                repeat (4) @(posedge clk);
                #1 sck = 1'b0;
            end
        end
        repeat (4) @(posedge clk);
        #1 cs_n = 1'b1;
        dq = ~dq;
        repeat (8) @(posedge clk);
    endtask : send

    // Accelerating voltage level, raised by the host inside the window.
    task automatic set_vpp(input logic v);
        @(posedge clk) #1 vpp_high = v;
    endtask : set_vpp
endmodule : spi_host_model

`default_nettype wire

// ===== bench/enhanced_volatile_config_tb.sv
// Self-checking bench for the enhanced volatile configuration block.
// Assumes the defines header and package are compiled beforehand.
`timescale 1ns/100ps
`default_nettype none

`include "flash_cfg_defines.svh"

module enhanced_volatile_config_tb
    import flash_cfg_pkg::*;
;
    logic clk = 1'b0;
    logic resetn;
    logic ce;
    logic cs_n;
    logic sck;
    logic [3:0] dq;
    logic vpp;
    logic nv_hold;
    logic [2:0] nv_drive;
    logic err_clear;
    cfg_s cfg;
    proto_e proto;
    logic hold_o;
    logic [2:0] drive_o;
    logic io2_en;
    logic temp_ext;
    logic accel;
    logic vpp_err;
    int num_errors = 0;
    int check_count = 0;
    logic [31:0] rng = 32'hB98BACA0;
    logic [7:0] cur;
    proto_e host_p;
    // Protocol walk and reserved drive codes written first.
    logic [7:0] walk [6] = '{8'h7F, 8'h3F, 8'hBF, 8'hFF, 8'hE8, 8'hEC};

    // Short window keeps the run brief; expectations use the same value.
    localparam int TMO = 400;

    always #10 clk = ~clk;

    enhanced_volatile_config #(.TIMEOUT_CYCLES(TMO)) u_dut (
        .clk(clk), .resetn(resetn), .ce(ce), .cs_n_pin(cs_n),
        .sck_pin(sck), .dq_pin(dq), .vpp_high_pin(vpp),
        .nonvolatile_config_reg_hold_en(nv_hold), .nonvolatile_config_reg_drive(nv_drive),
        .vpp_error_clear(err_clear), .cfg_r(cfg), .active_proto_r(proto),
        .hold_reset_en_r(hold_o), .drive_code_r(drive_o),
        .io2_accel_pin_en_r(io2_en), .temp_ext_r(temp_ext),
        .accel_active_r(accel), .vpp_error_r(vpp_err)
    );

    spi_host_model u_host (
        .clk(clk), .cs_n(cs_n), .sck(sck), .dq(dq), .vpp_high(vpp)
    );

    // ==================================================================
    // Helpers
    function automatic logic [31:0] xs();
        rng = rng ^ (rng << 13);
        rng = rng ^ (rng >> 17);
        rng = rng ^ (rng << 5);
        return rng;
    endfunction : xs

    // Quad wins whenever its bit is clear.
    function automatic proto_e exp_proto(input logic [7:0] c);
        return !c[7] ? PROTO_QUAD : (!c[6] ? PROTO_DUAL : PROTO_EXT);
    endfunction : exp_proto

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        check_count++;
        if (got !== exp) begin
            num_errors++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    // Sample 2 ns after the edge so host and bench updates have landed.
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #2;
    endtask : tick

    task automatic wr(input logic [7:0] d);
        u_host.send({`OP_WRITE_CFG, d, 24'h0}, 2, host_p);
        tick(2);
        cur = d & `CFG_WRITE_MASK;
        host_p = exp_proto(cur);
        chk(cfg, cur);
        chk({6'h00, proto}, {6'h00, host_p});
        chk({7'h00, hold_o}, {7'h00, cur[4]});
        chk({5'h00, drive_o}, {5'h00, cur[2:0]});
    endtask : wr

    task automatic modify(input logic [7:0] op, input int n);
        u_host.send({op, xs()}, n, host_p);
        tick(2);
    endtask : modify

    task automatic conclude();
        $display("checks=%0d errors=%0d", check_count, num_errors);
        if (num_errors == 0 && check_count > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : conclude

    // ==================================================================
    // Watchdog, well beyond the roughly 70 us the sequence needs.
    initial begin
        #400000;
        num_errors++;
        conclude();
    end

    // ==================================================================
    // Main sequence
    initial begin
        resetn = 1'b0;
        ce = 1'b1;
        err_clear = 1'b0;
        nv_hold = 1'b0;
        nv_drive = 3'(xs());
        host_p = PROTO_EXT;
        tick(2);
        chk(cfg, 8'hDF);
        chk({6'h00, proto}, {6'h00, PROTO_EXT});
        @(posedge clk) #1 resetn = 1'b1;
        tick(5);
        cur = {3'h6, nv_hold, 1'b1, nv_drive};
        chk(cfg, cur);
        chk({7'h00, hold_o}, {7'h00, nv_hold});
        chk({5'h00, drive_o}, {5'h00, nv_drive});
        // Protocol walk and reserved drive codes, then random values.
        foreach (walk[i]) begin
            wr(walk[i]);
        end
        for (int i = 0; i < 16; i++) begin
            wr(8'(xs()));
        end
        // A write frame without its data byte changes nothing.
        u_host.send({`OP_WRITE_CFG, 32'h0}, 1, host_p);
        tick(2);
        chk(cfg, cur);
        // Quad erase with acceleration allowed: temporary extended.
        wr(8'h57);
        modify(`OP_SECTOR_ERASE, 1);
        chk({7'h00, temp_ext}, 8'h01);
        chk({6'h00, proto}, {6'h00, PROTO_EXT});
        chk({7'h00, io2_en}, 8'h01);
        u_host.send({8'h05, 32'h0}, 1, PROTO_EXT);
        tick(1);
        chk({7'h00, temp_ext}, 8'h01);
        chk({6'h00, proto}, {6'h00, PROTO_EXT});
        u_host.set_vpp(1'b1);
        tick(6);
        chk({7'h00, accel}, 8'h01);
        u_host.set_vpp(1'b0);
        tick(6);
        chk({6'h00, accel, temp_ext}, 8'h00);
        chk({6'h00, proto}, {6'h00, PROTO_QUAD});
        chk({7'h00, vpp_err}, 8'h00);
        // Voltage never rises: error after the window, then cleared.
        modify(`OP_SUBSECTOR_ERASE, 1);
        chk({7'h00, temp_ext}, 8'h01);
        tick(TMO + 10);
        chk({7'h00, vpp_err}, 8'h01);
        chk({7'h00, temp_ext}, 8'h00);
        @(posedge clk) #1 err_clear = 1'b1;
        @(posedge clk) #1 err_clear = 1'b0;
        tick(2);
        chk({7'h00, vpp_err}, 8'h00);
        // An empty frame after an erase must not start anything.
        u_host.send(40'h0, 0, host_p);
        tick(2);
        chk({6'h00, io2_en, temp_ext}, 8'h00);
        // Quad page program needs all its data before it counts.
        modify(`OP_QUAD_PAGE_PROG, 4);
        chk({6'h00, io2_en, temp_ext}, 8'h00);
        modify(`OP_QUAD_PAGE_PROG, 5);
        chk({6'h00, io2_en, temp_ext}, 8'h03);
        u_host.set_vpp(1'b1);
        tick(6);
        u_host.set_vpp(1'b0);
        tick(6);
        chk({5'h00, vpp_err, accel, temp_ext}, 8'h00);
        chk({6'h00, proto}, {6'h00, PROTO_QUAD});
        // Extended protocol: erase ignored, quad fast program honoured.
        wr(8'hD7);
        modify(`OP_BULK_ERASE, 1);
        chk({6'h00, io2_en, temp_ext}, 8'h00);
        modify(`OP_QUAD_FAST_PROG, 5);
        chk({6'h00, io2_en, temp_ext}, 8'h02);
        u_host.set_vpp(1'b1);
        tick(6);
        chk({7'h00, accel}, 8'h01);
        u_host.set_vpp(1'b0);
        tick(6);
        // Default bit 3 set: quad erase leaves the pin alone.
        wr(8'h5F);
        modify(`OP_SECTOR_ERASE, 1);
        chk({6'h00, io2_en, temp_ext}, 8'h00);
        conclude();
    end
endmodule : enhanced_volatile_config_tb

`default_nettype wire
